// *** src/pwg_pkg.sv ***
// Package with register map, field positions and states of the PWM channel
package pwg_pkg;
	localparam int          PWG_AW        = 6;
	localparam logic [5:0]  PWG_OFS_MODE  = 6'h00;
	localparam logic [5:0]  PWG_OFS_ENA   = 6'h04;
	localparam logic [5:0]  PWG_OFS_PER   = 6'h08;
	localparam logic [5:0]  PWG_OFS_DUTY  = 6'h0C;
	localparam logic [5:0]  PWG_OFS_POL   = 6'h10;
	localparam logic [5:0]  PWG_OFS_DT    = 6'h14;
	localparam logic [5:0]  PWG_OFS_STAT  = 6'h18;
	localparam logic [5:0]  PWG_OFS_MASK  = 6'h1C;
	localparam logic [5:0]  PWG_OFS_STATE = 6'h20;
	// Mode register bit positions
	localparam int PWG_B_CENTER_ALIGN_SELECT = 0;
	localparam int PWG_B_CES  = 1;
	localparam int PWG_B_UPDATE_TIMING_SELECT = 2;
	localparam int PWG_B_DPOL = 3;
	localparam int PWG_B_CHANNEL_POLARITY = 4;
	localparam int PWG_B_TRIGGER_SOURCE_SELECT = 5;
	localparam int PWG_B_DTE  = 6;
	localparam int PWG_B_HIGH_SIDE_INVERT = 7;
	localparam int PWG_B_LOW_SIDE_INVERT = 8;
	localparam int PWG_B_PPM  = 9;
	localparam int PWG_MODE_W = 10;
	// Status and mask bit positions
	localparam int PWG_S_EVT  = 0;
	localparam int PWG_S_UPD  = 1;
	localparam int PWG_S_W    = 2;
	// Dead-time register fields
	localparam int PWG_DT_W   = 8;
	localparam int PWG_DTL_LSB = 8;
	// Reset values
	localparam logic [15:0] PWG_PER_RST  = 16'h0064;
	localparam logic [15:0] PWG_DUTY_RST = 16'h0000;
	localparam logic [31:0] PWG_ZERO     = 32'h0000_0000;
	typedef enum logic [1:0] {
		PWG_UP   = 2'b01,
		PWG_DOWN = 2'b10
	} pwg_dir_t;
endpackage

// *** src/pwg_deadtime.sv ***
// Dead-time generator producing high-side and low-side waveforms
`timescale 1ns/1ps
module pwg_deadtime
	import pwg_pkg::*;
(
	// Clock and reset
	input  wire logic                ref_clk_in,
	input  wire logic                reset_n_in,
	// Control
	input  wire logic                enable_in,
	input  wire logic                oc_in,
	input  wire logic [PWG_DT_W-1:0] dt_high_in,
	input  wire logic [PWG_DT_W-1:0] dt_low_in,
	// Waveforms
	output logic                     high_out,
	output logic                     low_out
);
	typedef struct packed {
		logic                prev;
		logic [PWG_DT_W-1:0] cnt_h;
		logic [PWG_DT_W-1:0] cnt_l;
		logic                high;
		logic                low;
	} pwg_dt_t;

	pwg_dt_t st;
	pwg_dt_t next_st;

	always_comb begin
		next_st = st;
		next_st.prev = oc_in;
		if (!enable_in) begin // RULE_07
			next_st.cnt_h = '0;
			next_st.cnt_l = '0;
			next_st.high  = oc_in;
			next_st.low   = !oc_in;
		end else begin
			// Each edge delays the rising side by its own dead time
			if (oc_in && !st.prev)
				next_st.cnt_h = dt_high_in;
			else if (st.cnt_h != '0)
				next_st.cnt_h = st.cnt_h - 1'b1;
			if (!oc_in && st.prev)
				next_st.cnt_l = dt_low_in;
			else if (st.cnt_l != '0)
				next_st.cnt_l = st.cnt_l - 1'b1;
			next_st.high = oc_in && (next_st.cnt_h == '0);
			next_st.low  = !oc_in && (next_st.cnt_l == '0);
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in)
			st <= '0;
		else
			st <= next_st;
	end

	assign high_out = st.high;
	assign low_out  = st.low;

	a_dt_bypass: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE_07
		(reset_n_in && !enable_in) |=> (high_out == $past(oc_in)) && (low_out == !$past(oc_in)))
		else $error("dead-time bypass does not follow compare output");
	a_dt_no_overlap: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE_07
		enable_in |=> !(high_out && low_out))
		else $error("dead-time outputs overlap");
endmodule // pwg_deadtime

// *** src/pwg_channel.sv ***
// PWM channel with mode options, dead time, push-pull and Avalon-MM registers
//
// Contract
// RULE_01 - Left aligned: counter event only at period end, whatever event select holds.
// RULE_02 - Center aligned: event select 0 gives period end, 1 adds half period.
// RULE_03 - Left aligned: buffered duty/polarity apply at period end after the write.
// RULE_04 - Center aligned: update select 0 applies at period end, 1 at half period.
// RULE_05 - Disabled channel outputs polarity level, inverted when disabled-invert is set.
// RULE_06 - Timer trigger is compare output when select 0, counter events when 1.
// RULE_07 - Dead-time generator works only when its enable bit is set, else bypassed.
// RULE_08 - High-side dead-time output inverted when high-side invert bit is set.
// RULE_09 - Low-side dead-time output inverted when low-side invert bit is set.
// RULE_10 - Push-pull alternation applies only when push-pull enable is set.
`timescale 1ns/1ps
module pwg_channel
	import pwg_pkg::*;
#(
	parameter logic [7:0] PRESCALE = 8'h01
)(
	// Clock and reset
	input  wire logic              ref_clk_in,
	input  wire logic              reset_n_in,
	// Avalon-MM slave
	input  wire logic [PWG_AW-1:0] avs_address_in,
	input  wire logic              avs_read_in,
	input  wire logic              avs_write_in,
	input  wire logic [31:0]       avs_writedata_in,
	input  wire logic [3:0]        avs_byteenable_in,
	output logic [31:0]            avs_readdata_out,
	output logic                   avs_waitrequest_out,
	// Pins and timer counter
	output logic                   channel_compare_output_out,
	output logic                   high_side_output_out,
	output logic                   low_side_output_out,
	output logic                   tc_trigger_out,
	// Interrupt
	output logic                   irq_out
);
	typedef struct packed {
		logic                  ack;
		logic [31:0]           rdata;
		logic [PWG_MODE_W-1:0] mode;
		logic                  enable;
		logic [15:0]           period;
		logic [15:0]           duty_pend;
		logic                  pol_pend;
		logic                  pend;
		logic [15:0]           duty;
		logic                  pol;
		logic [15:0]           dt;
		logic [PWG_S_W-1:0]    status;
		logic [PWG_S_W-1:0]    mask;
		logic [15:0]           cnt;
		pwg_dir_t              dir;
		logic [7:0]            presc;
		logic                  phase;
		logic                  oc;
		logic                  trig;
		logic                  high;
		logic                  low;
	} pwg_state_t;

	pwg_state_t st;
	pwg_state_t next_st;

	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
			input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = new_v[i*8 +: 8];
		return r;
	endfunction

	logic              req;
	logic              wr_go;
	logic              rd_go;
	logic              tick;
	logic              center;
	logic              end_evt;
	logic              half_evt;
	logic              ch_event;
	logic              bnd;
	logic              apply;
	logic              upd_write;
	logic              cmp;
	logic              oc_level;
	logic              dt_high;
	logic              dt_low;
	logic              pp_high;
	logic              pp_low;
	logic [31:0]       wv;

	assign req                 = avs_read_in || avs_write_in;
	assign avs_waitrequest_out = req && !st.ack;
	assign wr_go               = avs_write_in && st.ack;
	assign rd_go               = avs_read_in && st.ack;
	assign center              = st.mode[PWG_B_CENTER_ALIGN_SELECT];
	assign tick                = st.enable && (st.presc == PRESCALE - 8'h01);

	// Period boundaries of the running counter
	always_comb begin
		end_evt  = 1'b0;
		half_evt = 1'b0;
		if (tick) begin
			unique case (st.dir)
				PWG_UP: begin
					if (!center)
						end_evt = (st.cnt == st.period - 16'h0001);
					else
						half_evt = (st.cnt == st.period - 16'h0001);
				end
				PWG_DOWN: end_evt = (st.cnt == 16'h0001);
				default: ;
			endcase
		end
	end

	assign ch_event  = end_evt || (center && st.mode[PWG_B_CES] && half_evt); // RULE_01 RULE_02
	assign bnd       = (center && st.mode[PWG_B_UPDATE_TIMING_SELECT]) ? (end_evt || half_evt) // RULE_04
		: end_evt; // RULE_03
	assign apply     = st.pend && (bnd || !st.enable);
	assign upd_write = wr_go && (avs_address_in == PWG_OFS_DUTY || avs_address_in == PWG_OFS_POL);
	assign cmp       = st.cnt < st.duty;
	assign oc_level  = st.enable ? (st.pol ? cmp : !cmp)
		: (st.pol ^ st.mode[PWG_B_DPOL]); // RULE_05

	pwg_deadtime u_deadtime (
		.ref_clk_in (ref_clk_in),
		.reset_n_in (reset_n_in),
		.enable_in  (st.mode[PWG_B_DTE]), // RULE_07
		.oc_in      (st.oc),
		.dt_high_in (st.dt[PWG_DT_W-1:0]),
		.dt_low_in  (st.dt[PWG_DTL_LSB +: PWG_DT_W]),
		.high_out   (dt_high),
		.low_out    (dt_low)
	);

	// Push-pull routes alternate periods to alternate sides
	assign pp_high = st.mode[PWG_B_PPM] ? (dt_high && !st.phase) : dt_high; // RULE_10
	assign pp_low  = st.mode[PWG_B_PPM] ? (dt_high && st.phase) : dt_low; // RULE_10

	always_comb begin
		next_st = st;
		wv      = PWG_ZERO;
		next_st.ack = req && !st.ack;
		// Read data captured one cycle before the answer
		if (avs_read_in && !st.ack) begin
			unique case (avs_address_in)
				PWG_OFS_MODE:  next_st.rdata = {22'h00_0000, st.mode};
				PWG_OFS_ENA:   next_st.rdata = {31'h0000_0000, st.enable};
				PWG_OFS_PER:   next_st.rdata = {16'h0000, st.period};
				PWG_OFS_DUTY:  next_st.rdata = {16'h0000, st.duty_pend};
				PWG_OFS_POL:   next_st.rdata = {31'h0000_0000, st.pol_pend};
				PWG_OFS_DT:    next_st.rdata = {16'h0000, st.dt};
				PWG_OFS_STAT:  next_st.rdata = {30'h0000_0000, st.status};
				PWG_OFS_MASK:  next_st.rdata = {30'h0000_0000, st.mask};
				PWG_OFS_STATE: next_st.rdata = {st.dir == PWG_DOWN, st.pend, st.pol,
					13'h0000, st.cnt};
				default:       next_st.rdata = PWG_ZERO;
			endcase
		end
		// Counter and prescaler
		if (!st.enable) begin
			next_st.presc = '0;
			next_st.cnt   = '0;
			next_st.dir   = PWG_UP;
		end else begin
			next_st.presc = tick ? 8'h00 : st.presc + 8'h01;
			if (tick) begin
				unique case (st.dir)
					PWG_UP: begin
						if (end_evt)
							next_st.cnt = '0;
						else
							next_st.cnt = st.cnt + 16'h0001;
						if (half_evt)
							next_st.dir = PWG_DOWN;
					end
					PWG_DOWN: begin
						next_st.cnt = st.cnt - 16'h0001;
						if (end_evt)
							next_st.dir = PWG_UP;
					end
					default: next_st.dir = PWG_UP;
				endcase
			end
		end
		if (end_evt)
			next_st.phase = !st.phase;
		// Buffered update takes effect at the selected boundary, or at once while the channel is disabled
		if (apply) begin // RULE_03 RULE_04
			next_st.duty = st.duty_pend;
			next_st.pol  = st.pol_pend;
			next_st.pend = 1'b0;
		end
		// Status read clears only the bits it reported, new events win
		if (rd_go && avs_address_in == PWG_OFS_STAT)
			next_st.status = st.status & ~st.rdata[PWG_S_W-1:0];
		if (ch_event)
			next_st.status[PWG_S_EVT] = 1'b1; // RULE_02
		if (apply)
			next_st.status[PWG_S_UPD] = 1'b1;
		if (wr_go) begin
			unique case (avs_address_in)
				PWG_OFS_MODE: begin
					wv = merge({22'h00_0000, st.mode}, avs_writedata_in, avs_byteenable_in);
					next_st.mode = wv[PWG_MODE_W-1:0];
				end
				PWG_OFS_ENA: begin
					if (avs_byteenable_in[0])
						next_st.enable = avs_writedata_in[0];
				end
				PWG_OFS_PER: begin
					wv = merge({16'h0000, st.period}, avs_writedata_in, avs_byteenable_in);
					next_st.period = wv[15:0];
				end
				PWG_OFS_DUTY: begin
					wv = merge({16'h0000, st.duty_pend}, avs_writedata_in, avs_byteenable_in);
					next_st.duty_pend = wv[15:0];
				end
				PWG_OFS_POL: begin
					if (avs_byteenable_in[0])
						next_st.pol_pend = avs_writedata_in[0];
				end
				PWG_OFS_DT: begin
					wv = merge({16'h0000, st.dt}, avs_writedata_in, avs_byteenable_in);
					next_st.dt = wv[15:0];
				end
				PWG_OFS_MASK: begin
					wv = merge({30'h0000_0000, st.mask}, avs_writedata_in, avs_byteenable_in);
					next_st.mask = wv[PWG_S_W-1:0];
				end
				default: ;
			endcase
		end
		if (upd_write)
			next_st.pend = 1'b1;
		// Registered pin and trigger outputs
		next_st.oc   = oc_level;
		next_st.trig = st.mode[PWG_B_TRIGGER_SOURCE_SELECT] ? ch_event : oc_level; // RULE_06
		next_st.high = pp_high ^ st.mode[PWG_B_HIGH_SIDE_INVERT]; // RULE_08
		next_st.low  = pp_low ^ st.mode[PWG_B_LOW_SIDE_INVERT]; // RULE_09
	end

	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			st        <= '0;
			st.period <= PWG_PER_RST;
			st.duty   <= PWG_DUTY_RST;
			st.dir    <= PWG_UP;
		end else begin
			st <= next_st;
		end
	end

	assign avs_readdata_out           = st.rdata;
	assign channel_compare_output_out = st.oc;
	assign high_side_output_out       = st.high;
	assign low_side_output_out        = st.low;
	assign tc_trigger_out             = st.trig;
	assign irq_out                    = |(st.status & st.mask);

	a_left_event_end: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE_01
		(!center && tick && st.dir == PWG_UP && st.cnt != st.period - 16'h0001) |-> !ch_event)
		else $error("left aligned event away from period end");
	a_center_half_evt: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE_02
		(center && st.mode[PWG_B_CES] && half_evt) |=> st.status[PWG_S_EVT])
		else $error("half period event not flagged");
	a_center_no_half: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE_02
		(center && !st.mode[PWG_B_CES] && st.dir == PWG_UP) |-> !ch_event)
		else $error("event on counting up with event select 0");
	a_left_update_end: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE_03
		(st.enable && !center && $changed(st.duty)) |-> $past(end_evt))
		else $error("left aligned duty changed away from period end");
	a_center_upd_half: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE_04
		(center && st.mode[PWG_B_UPDATE_TIMING_SELECT] && st.pend && half_evt && !upd_write)
		|=> !st.pend && st.duty == $past(st.duty_pend))
		else $error("half period update not applied");
	a_center_upd_full: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE_04
		(st.enable && center && !st.mode[PWG_B_UPDATE_TIMING_SELECT] && st.pend && half_evt) |=> st.pend)
		else $error("update applied at half period with update select 0");
	a_disabled_level: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE_05
		!st.enable |=> channel_compare_output_out == ($past(st.pol) ^ $past(st.mode[PWG_B_DPOL])))
		else $error("disabled output level wrong");
	a_trigger_source: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE_06
		st.mode[PWG_B_TRIGGER_SOURCE_SELECT] |=> tc_trigger_out == $past(ch_event))
		else $error("trigger does not follow counter events");
	a_trigger_compare: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE_06
		!st.mode[PWG_B_TRIGGER_SOURCE_SELECT] ##1 !$past(st.mode[PWG_B_TRIGGER_SOURCE_SELECT])
		|-> tc_trigger_out == channel_compare_output_out)
		else $error("trigger does not follow compare output");
	a_high_invert: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE_08
		1'b1 |=> high_side_output_out == ($past(pp_high) ^ $past(st.mode[PWG_B_HIGH_SIDE_INVERT])))
		else $error("high side inversion wrong");
	a_low_invert: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE_09
		1'b1 |=> low_side_output_out == ($past(pp_low) ^ $past(st.mode[PWG_B_LOW_SIDE_INVERT])))
		else $error("low side inversion wrong");
	a_pushpull_off: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE_10
		(st.mode[PWG_B_PPM] && st.phase) |=> high_side_output_out == $past(st.mode[PWG_B_HIGH_SIDE_INVERT]))
		else $error("push-pull high side active in odd period");

	c_center_half: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in)
		center && st.mode[PWG_B_CES] && half_evt);
	c_update_half: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in)
		center && st.mode[PWG_B_UPDATE_TIMING_SELECT] && apply && half_evt);
	c_irq: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in) irq_out);
	c_pushpull: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in)
		st.mode[PWG_B_PPM] && end_evt);
endmodule // pwg_channel

// *** testbench/pwg_tc_model.sv ***
// Far-side model: timer counter trigger input and PWM pins, counting high cycles
`timescale 1ns/1ps
module pwg_tc_model (
	// Clock and clear
	input  wire logic        ref_clk_in,
	input  wire logic        clear_in,
	// Observed signals
	input  wire logic        trigger_in,
	input  wire logic        high_pin_in,
	input  wire logic        low_pin_in,
	// Counts of high cycles
	output logic [15:0]      trig_cnt_out,
	output logic [15:0]      high_cnt_out,
	output logic [15:0]      low_cnt_out
);
	always_ff @(posedge ref_clk_in) begin
		if (clear_in) begin
			trig_cnt_out <= 16'h0000;
			high_cnt_out <= 16'h0000;
			low_cnt_out  <= 16'h0000;
		end else begin
			trig_cnt_out <= trig_cnt_out + 16'(trigger_in);
			high_cnt_out <= high_cnt_out + 16'(high_pin_in);
			low_cnt_out  <= low_cnt_out + 16'(low_pin_in);
		end
	end
endmodule // pwg_tc_model

// *** testbench/pwm_channel_mode_options_bench.sv ***
// Self-checking bench for the PWM channel mode options
`timescale 1ns/1ps
module pwm_channel_mode_options_bench
	import pwg_pkg::*;
;
	logic              ref_clk_in = 1'b0;
	logic              reset_n_in = 1'b0;
	logic [PWG_AW-1:0] avs_address_in = '0;
	logic              avs_read_in = 1'b0;
	logic              avs_write_in = 1'b0;
	logic [31:0]       avs_writedata_in = '0;
	logic [3:0]        avs_byteenable_in = 4'hF;
	logic [31:0]       avs_readdata_out;
	logic              avs_waitrequest_out;
	logic              channel_compare_output_out;
	logic              high_side_output_out;
	logic              low_side_output_out;
	logic              tc_trigger_out;
	logic              irq_out;
	logic              clr = 1'b1;
	logic [15:0]       trig_cnt;
	logic [15:0]       high_cnt;
	logic [15:0]       low_cnt;
	logic [31:0]       q;
	int                err_total = 0;
	int                comparisons = 0;

	always #50 ref_clk_in = ~ref_clk_in;

	pwg_channel u_pwg_channel (
		.ref_clk_in                 (ref_clk_in),
		.reset_n_in                 (reset_n_in),
		.avs_address_in             (avs_address_in),
		.avs_read_in                (avs_read_in),
		.avs_write_in               (avs_write_in),
		.avs_writedata_in           (avs_writedata_in),
		.avs_byteenable_in          (avs_byteenable_in),
		.avs_readdata_out           (avs_readdata_out),
		.avs_waitrequest_out        (avs_waitrequest_out),
		.channel_compare_output_out (channel_compare_output_out),
		.high_side_output_out       (high_side_output_out),
		.low_side_output_out        (low_side_output_out),
		.tc_trigger_out             (tc_trigger_out),
		.irq_out                    (irq_out)
	);

	pwg_tc_model u_pwg_tc_model (
		.ref_clk_in   (ref_clk_in),
		.clear_in     (clr),
		.trigger_in   (tc_trigger_out),
		.high_pin_in  (high_side_output_out),
		.low_pin_in   (low_side_output_out),
		.trig_cnt_out (trig_cnt),
		.high_cnt_out (high_cnt),
		.low_cnt_out  (low_cnt)
	);

	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One Avalon-MM transfer, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
			output logic [31:0] rdata);
		int n;
		n = 0;
		@(posedge ref_clk_in);
		avs_address_in   <= a;
		avs_writedata_in <= d;
		avs_read_in      <= !wr;
		avs_write_in     <= wr;
		do begin
			@(posedge ref_clk_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0 && n < 50);
		if (n >= 50) begin
			err_total++;
			$display("MISMATCH waitrequest expected 0 seen stuck");
			print_verdict();
		end
		rdata = avs_readdata_out;
		avs_read_in  <= 1'b0;
		avs_write_in <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		bus(1'b1, a, d, dummy);
	endtask

	task automatic rd(input logic [5:0] a, output logic [31:0] rdata);
		bus(1'b0, a, 32'h0000_0000, rdata);
	endtask

	function automatic logic [31:0] mb(input int b);
		return 32'h0000_0001 << b;
	endfunction

	// Writes a mode, lets it settle, then counts 80 cycles of pins and trigger
	task automatic measure(input logic [31:0] mode);
		wr(PWG_OFS_MODE, mode);
		repeat (16) @(posedge ref_clk_in);
		clr <= 1'b1;
		@(posedge ref_clk_in);
		clr <= 1'b0;
		repeat (81) @(posedge ref_clk_in);
	endtask

	task automatic done(input string name);
		$display("test %s finished, mismatches so far %0d", name, err_total);
	endtask

	initial begin
		repeat (3) @(posedge ref_clk_in);
		reset_n_in <= 1'b1;
		rd(PWG_OFS_PER, q);
		cmp("period reset", 32'h0000_0064, q);
		rd(PWG_OFS_MODE, q);
		cmp("mode reset", 32'h0000_0000, q);
		rd(6'h3C, q);
		cmp("unmapped read", 32'h0000_0000, q);
		done("reset");

		wr(PWG_OFS_POL, 32'h0000_0001);
		wr(PWG_OFS_MODE, 32'h0000_0000);
		repeat (3) @(posedge ref_clk_in);
		cmp("disabled level", 32'(1'b1), 32'(channel_compare_output_out));
		wr(PWG_OFS_MODE, mb(PWG_B_DPOL));
		repeat (3) @(posedge ref_clk_in);
		cmp("disabled inverted", 32'(1'b0), 32'(channel_compare_output_out));
		done("disabled");

		wr(PWG_OFS_PER, 32'h0000_0004);
		wr(PWG_OFS_DUTY, 32'h0000_0003);
		wr(PWG_OFS_ENA, 32'h0000_0001);
		measure(mb(PWG_B_CES) | mb(PWG_B_TRIGGER_SOURCE_SELECT));
		cmp("left events", 32'h0000_0014, 32'(trig_cnt));
		cmp("high bypass", 32'h0000_003C, 32'(high_cnt));
		cmp("low bypass", 32'h0000_0014, 32'(low_cnt));
		measure(mb(PWG_B_CENTER_ALIGN_SELECT) | mb(PWG_B_TRIGGER_SOURCE_SELECT));
		cmp("center end events", 32'h0000_000A, 32'(trig_cnt));
		measure(mb(PWG_B_CENTER_ALIGN_SELECT) | mb(PWG_B_CES) | mb(PWG_B_TRIGGER_SOURCE_SELECT));
		cmp("center both events", 32'h0000_0014, 32'(trig_cnt));
		done("events");

		measure(32'h0000_0000);
		cmp("compare trigger", 32'h0000_003C, 32'(trig_cnt));
		measure(mb(PWG_B_HIGH_SIDE_INVERT));
		cmp("high inverted", 32'h0000_0014, 32'(high_cnt));
		measure(mb(PWG_B_LOW_SIDE_INVERT));
		cmp("low inverted", 32'h0000_003C, 32'(low_cnt));
		wr(PWG_OFS_DT, 32'h0000_0101);
		measure(mb(PWG_B_DTE));
		cmp("high dead time", 32'h0000_0028, 32'(high_cnt));
		cmp("low dead time", 32'h0000_0000, 32'(low_cnt));
		measure(mb(PWG_B_PPM));
		cmp("push pull high", 32'h0000_001E, 32'(high_cnt));
		cmp("push pull low", 32'h0000_001E, 32'(low_cnt));
		done("outputs");

		wr(PWG_OFS_MASK, mb(PWG_S_UPD));
		measure(32'h0000_0000);
		rd(PWG_OFS_STAT, q);
		@(posedge ref_clk_in);
		cmp("irq cleared", 32'(1'b0), 32'(irq_out));
		wr(PWG_OFS_DUTY, 32'h0000_0001);
		measure(32'h0000_0000);
		cmp("duty applied", 32'h0000_0014, 32'(high_cnt));
		cmp("irq raised", 32'(1'b1), 32'(irq_out));
		rd(PWG_OFS_STAT, q);
		cmp("update flag", mb(PWG_S_UPD), q & mb(PWG_S_UPD));
		@(posedge ref_clk_in);
		cmp("irq after read", 32'(1'b0), 32'(irq_out));
		wr(PWG_OFS_MODE, mb(PWG_B_CENTER_ALIGN_SELECT) | mb(PWG_B_UPDATE_TIMING_SELECT));
		rd(PWG_OFS_STAT, q);
		wr(PWG_OFS_DUTY, 32'h0000_0002);
		repeat (6) @(posedge ref_clk_in);
		cmp("half period update", 32'(1'b1), 32'(irq_out));
		done("updates");
		print_verdict();
	end
endmodule // pwm_channel_mode_options_bench
